// ===== logic/flash_ctl_pkg.sv
// Package with register map, field layout, encodings and carriers of the flash controller.
package flash_ctl_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CLKCFG_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_ERASE   = 0;
   localparam int CTRL_MASS    = 1;
   localparam int CTRL_GMASS   = 2;
   localparam int CTRL_ARRSEL  = 3;
   localparam int CTRL_WREN    = 6;
   localparam int CTRL_BLKWR   = 7;
   localparam int CLK_SRC_LO   = 0;
   localparam int CLK_DIV_LO   = 2;
   localparam int CLK_DIV_W    = 6;
   localparam int ST_BUSY      = 0;
   localparam int ST_LOCK      = 1;
   localparam int ST_ACCV      = 2;
   localparam int ST_WAIT      = 3;

   // ------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [7:0]  CLKCFG_RST = 8'h00;
   localparam logic        LOCK_RST   = 1'b1;
   localparam logic [15:0] JMP_SELF   = 16'h3FFF;
   localparam int          TAIL_TICKS = 3;

   // Timing-generator frequency window that software must respect.
   localparam int FTG_MIN_KHZ = 257;
   localparam int FTG_MAX_KHZ = 476;

   typedef enum logic [1:0] {
      SRC_AUX  = 2'b00,
      SRC_SUB  = 2'b01,
      SRC_MAIN = 2'b10
   } clk_src_t;

   typedef enum logic [1:0] {
      VAR_BASIC = 2'b00,
      VAR_DUAL  = 2'b01,
      VAR_LOCK  = 2'b10
   } variant_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        req;
      logic        we;
      logic        fetch;
      logic        from_flash;
      logic [15:0] addr;
      logic [15:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic        tgen_on;
      logic        prog_v_on;
      logic        erase_v_on;
      logic        erase_seg;
      logic        erase_main;
      logic        erase_info;
      logic        erase_both;
      logic        arr_sel;
      logic [15:0] addr;
      logic [15:0] clr_mask;
   } arr_ctl_t;

endpackage

// ===== logic/flash_program_erase_controller.sv
// Flash program/erase sequencer with APB registers and processor-side flash port.
`timescale 1ns/1ps
module flash_program_erase_controller #(
   parameter flash_ctl_pkg::variant_t VARIANT = flash_ctl_pkg::VAR_BASIC,
   parameter logic [15:0] INFO_BASE      = 16'h1000,
   parameter logic [15:0] INFO_END       = 16'h10FF,
   parameter logic [15:0] INFOA_BASE     = 16'h1080,
   parameter logic [15:0] MAIN_BASE      = 16'h4000,
   parameter logic [15:0] ARR1_BASE      = 16'hA000,
   parameter logic [15:0] ERASE_TICKS    = 16'd4800,
   parameter logic [15:0] WORD_TICKS     = 16'd35,
   parameter logic [15:0] BLK_WORD_TICKS = 16'd30,
   parameter logic [15:0] BLK_END_TICKS  = 16'd6
) (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    aux_clk_tick,
   input  wire logic                    sub_main_clock_tick,
   input  wire flash_ctl_pkg::cpu_req_t cpu,
   output logic [15:0]                  cpu_rdata,
   output logic                         cpu_stall,
   input  wire logic [15:0]             arr_rdata,
   output flash_ctl_pkg::arr_ctl_t      arr
);

   // ------------------------------------------------------------
   // State and storage
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ERASE = 3'b001,
      ST_WRITE = 3'b010,
      ST_BPROG = 3'b011,
      ST_BWAIT = 3'b100,
      ST_BEND  = 3'b101
   } fsm_t;

   fsm_t        state_q;
   fsm_t        state_d;
   logic [7:0]  ctrl_q;
   logic [7:0]  clkcfg_q;
   logic        info_seg_lock_q;
   logic        access_violation_flag_q;
   logic        stall_mode_q;
   logic [15:0] tick_cnt_q;
   logic [5:0]  div_cnt_q;
   logic [15:0] op_addr_q;
   logic [15:0] op_mask_q;
   logic        busy;
   logic        ftg_tick;
   logic        src_tick;
   logic        apb_wr;
   logic        addr_ok;
   logic        op_done;
   logic        cpu_flash;
   logic        start_erase;
   logic        start_word;
   logic        start_block;
   logic        blk_next;
   logic        violation;

   wire logic global_mass_erase_sel = ctrl_q[flash_ctl_pkg::CTRL_GMASS];
   wire logic mass_erase_sel        = ctrl_q[flash_ctl_pkg::CTRL_MASS];
   wire logic erase_sel             = ctrl_q[flash_ctl_pkg::CTRL_ERASE];
   wire logic write_enable_bit      = ctrl_q[flash_ctl_pkg::CTRL_WREN];
   wire logic block_write_sel       = ctrl_q[flash_ctl_pkg::CTRL_BLKWR];
   wire logic [5:0] timing_clock_divider =
      clkcfg_q[flash_ctl_pkg::CLK_DIV_LO +: flash_ctl_pkg::CLK_DIV_W];

   // ------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------
   function automatic logic in_info(input logic [15:0] a);
      in_info = (a >= INFO_BASE) && (a <= INFO_END);
   endfunction

   function automatic logic in_main(input logic [15:0] a);
      in_main = (a >= MAIN_BASE);
   endfunction

   function automatic logic array_of(input logic [15:0] a);
      array_of = (VARIANT == flash_ctl_pkg::VAR_DUAL) && (a >= ARR1_BASE);
   endfunction

   // Info memory is writable unless it is the locked upper segment from INFOA_BASE in the VAR_LOCK variant.
   function automatic logic info_open(input logic [15:0] a, input logic lk);
      info_open = !((VARIANT == flash_ctl_pkg::VAR_LOCK) && lk && (a >= INFOA_BASE));
   endfunction

   // Dummy-write range check for the selected erase mode.
   function automatic logic erase_range(input logic [15:0] a, input logic [7:0] c,
                                        input logic lk);
      logic g;
      logic m;
      logic e;
      logic arr_hit;
      g = c[flash_ctl_pkg::CTRL_GMASS] && (VARIANT == flash_ctl_pkg::VAR_DUAL);
      m = c[flash_ctl_pkg::CTRL_MASS];
      e = c[flash_ctl_pkg::CTRL_ERASE];
      arr_hit = g || (array_of(a) == c[flash_ctl_pkg::CTRL_ARRSEL]);
      if (!m && e) begin
         erase_range = in_main(a) || (in_info(a) && info_open(a, lk));
      end else if (m && !e) begin
         erase_range = in_main(a) && arr_hit;
      end else if (m && e) begin
         erase_range = (in_main(a) && arr_hit) ||
                       (in_info(a) && !array_of(a) &&
                        !((VARIANT == flash_ctl_pkg::VAR_LOCK) && lk));
      end else begin
         erase_range = 1'b0;
      end
   endfunction

   // ------------------------------------------------------------
   // Processor request classification
   // ------------------------------------------------------------
   assign cpu_flash = cpu.req && (in_info(cpu.addr) || in_main(cpu.addr));
   assign addr_ok   = erase_range(cpu.addr, ctrl_q, info_seg_lock_q);

   assign start_erase = (state_q == ST_IDLE) && cpu_flash && cpu.we &&
                        (mass_erase_sel || erase_sel) && addr_ok;
   assign start_word  = (state_q == ST_IDLE) && cpu_flash && cpu.we &&
                        !mass_erase_sel && !erase_sel && write_enable_bit &&
                        !block_write_sel && (in_main(cpu.addr) ||
                        info_open(cpu.addr, info_seg_lock_q));
   assign start_block = (state_q == ST_IDLE) && cpu_flash && cpu.we && !cpu.from_flash &&
                        !mass_erase_sel && !erase_sel && write_enable_bit &&
                        block_write_sel && (in_main(cpu.addr) ||
                        info_open(cpu.addr, info_seg_lock_q));
   assign blk_next    = (state_q == ST_BWAIT) && cpu_flash && cpu.we && block_write_sel;

   assign violation = (busy && !stall_mode_q && cpu_flash && !blk_next) ||
                      ((state_q == ST_IDLE) && cpu_flash && cpu.we && !write_enable_bit &&
                       !mass_erase_sel && !erase_sel);

   // ------------------------------------------------------------
   // Timing generator
   // ------------------------------------------------------------
   // source select
   always_comb begin
      case (flash_ctl_pkg::clk_src_t'(clkcfg_q[flash_ctl_pkg::CLK_SRC_LO +: 2]))
         flash_ctl_pkg::SRC_AUX:  src_tick = aux_clk_tick;
         flash_ctl_pkg::SRC_SUB:  src_tick = sub_main_clock_tick;
         flash_ctl_pkg::SRC_MAIN: src_tick = 1'b1;
         default:                 src_tick = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn || !busy) begin
         div_cnt_q <= 6'h00;
      end else if (src_tick) begin
         div_cnt_q <= (div_cnt_q == timing_clock_divider) ? 6'h00 : div_cnt_q + 6'h01;
      end
   end

   assign ftg_tick = busy && src_tick && (div_cnt_q == timing_clock_divider);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      op_done = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (start_erase) begin
               state_d = ST_ERASE;
            end else if (start_word) begin
               state_d = ST_WRITE;
            end else if (start_block) begin
               state_d = ST_BPROG;
            end
         end
         ST_ERASE: begin
            if (ftg_tick && tick_cnt_q == ERASE_TICKS - 16'd1) begin
               state_d = ST_IDLE;
               op_done = 1'b1;
            end
         end
         ST_WRITE: begin
            if (ftg_tick && tick_cnt_q == WORD_TICKS - 16'd1) begin
               state_d = ST_IDLE;
               op_done = 1'b1;
            end
         end
         ST_BPROG: begin
            if (ftg_tick && tick_cnt_q == BLK_WORD_TICKS - 16'd1) begin
               state_d = ST_BWAIT;
            end
         end
         ST_BWAIT: begin
            if (blk_next) begin
               state_d = ST_BPROG;
            end else if (!block_write_sel) begin
               state_d = ST_BEND;
            end
         end
         ST_BEND: begin
            if (ftg_tick && tick_cnt_q == BLK_END_TICKS - 16'd1) begin
               state_d = ST_IDLE;
               op_done = 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || state_d != state_q) begin
         tick_cnt_q <= 16'h0000;
      end else if (ftg_tick) begin
         tick_cnt_q <= tick_cnt_q + 16'd1;
      end
   end

   // Operation address and clear mask are captured at the starting write and at each further block write.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         op_addr_q <= 16'h0000;
         op_mask_q <= 16'h0000;
      end else if (start_erase || start_word || start_block || blk_next) begin
         op_addr_q <= cpu.addr;
         op_mask_q <= ~cpu.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stall_mode_q <= 1'b0;
      end else if (start_erase || start_word) begin
         stall_mode_q <= cpu.from_flash;
      end else if (op_done) begin
         stall_mode_q <= 1'b0;
      end
   end

   assign busy = (state_q != ST_IDLE);

   // ------------------------------------------------------------
   // Array control and processor read path
   // ------------------------------------------------------------
   // read mode when idle
   assign arr.tgen_on    = busy;
   assign arr.prog_v_on  = (state_q == ST_WRITE &&
                            tick_cnt_q < WORD_TICKS - 16'(flash_ctl_pkg::TAIL_TICKS)) ||
                           state_q == ST_BPROG || state_q == ST_BWAIT;
   assign arr.erase_v_on = (state_q == ST_ERASE);
   assign arr.erase_seg  = erase_sel && !mass_erase_sel;
   assign arr.erase_main = mass_erase_sel;
   assign arr.erase_info = (mass_erase_sel && erase_sel &&
                            !((VARIANT == flash_ctl_pkg::VAR_LOCK) && info_seg_lock_q)) ||
                           (!mass_erase_sel && erase_sel && in_info(op_addr_q));
   assign arr.erase_both = global_mass_erase_sel && mass_erase_sel &&
                           (VARIANT == flash_ctl_pkg::VAR_DUAL);
   assign arr.arr_sel    = ctrl_q[flash_ctl_pkg::CTRL_ARRSEL];
   assign arr.addr       = busy ? op_addr_q : cpu.addr;
   assign arr.clr_mask   = op_mask_q;

   assign cpu_stall = busy && stall_mode_q;
   assign cpu_rdata = (cpu_stall && cpu.fetch) ? flash_ctl_pkg::JMP_SELF : arr_rdata;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign pready  = 1'b1;
   assign apb_wr  = psel && penable && pwrite;
   assign pslverr = psel && penable && (paddr != flash_ctl_pkg::CTRL_OFS) &&
                    (paddr != flash_ctl_pkg::CLKCFG_OFS) &&
                    (paddr != flash_ctl_pkg::STATUS_OFS);

   always_comb begin
      case (paddr)
         flash_ctl_pkg::CTRL_OFS:   prdata = {24'h000000, ctrl_q};
         flash_ctl_pkg::CLKCFG_OFS: prdata = {24'h000000, clkcfg_q};
         flash_ctl_pkg::STATUS_OFS: prdata = {28'h0000000, state_q == ST_BWAIT,
                                              access_violation_flag_q,
                                              info_seg_lock_q, busy};
         default:                   prdata = 32'h00000000;
      endcase
   end

   // Mode bits are frozen while busy, except that erase bits clear at completion and block-write and write-enable bits are writable in block programming.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_q <= flash_ctl_pkg::CTRL_RST;
      end else if (op_done) begin
         ctrl_q[flash_ctl_pkg::CTRL_GMASS] <= 1'b0;
         ctrl_q[flash_ctl_pkg::CTRL_MASS]  <= 1'b0;
         ctrl_q[flash_ctl_pkg::CTRL_ERASE] <= 1'b0;
      end else if (apb_wr && paddr == flash_ctl_pkg::CTRL_OFS) begin
         if (!busy) begin
            ctrl_q <= pwdata[7:0];
         end else if (state_q == ST_BPROG || state_q == ST_BWAIT) begin
            ctrl_q[flash_ctl_pkg::CTRL_BLKWR] <= pwdata[flash_ctl_pkg::CTRL_BLKWR];
            ctrl_q[flash_ctl_pkg::CTRL_WREN]  <= pwdata[flash_ctl_pkg::CTRL_WREN];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         clkcfg_q <= flash_ctl_pkg::CLKCFG_RST;
      end else if (apb_wr && paddr == flash_ctl_pkg::CLKCFG_OFS && !busy) begin
         clkcfg_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         info_seg_lock_q <= flash_ctl_pkg::LOCK_RST;
      end else if (apb_wr && paddr == flash_ctl_pkg::STATUS_OFS &&
                   pwdata[flash_ctl_pkg::ST_LOCK] && !busy) begin
         info_seg_lock_q <= ~info_seg_lock_q;
      end
   end

   // Violation flag is write-one-to-clear; a new violation wins over the clear.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         access_violation_flag_q <= 1'b0;
      end else if (violation) begin
         access_violation_flag_q <= 1'b1;
      end else if (apb_wr && paddr == flash_ctl_pkg::STATUS_OFS &&
                   pwdata[flash_ctl_pkg::ST_ACCV]) begin
         access_violation_flag_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_idle_read;
      @(posedge clk) disable iff (!rstn)
      !busy |-> !arr.tgen_on && !arr.prog_v_on && !arr.erase_v_on;
   endproperty
   a_idle_read: assert property (p_idle_read) else $error("generators on while idle");

   property p_busy_after_erase;
      @(posedge clk) disable iff (!rstn)
      start_erase |=> busy && arr.erase_v_on;
   endproperty
   a_busy_after_erase: assert property (p_busy_after_erase) else $error("no busy after erase");

   property p_clear_modes;
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_ERASE && state_d == ST_IDLE) |=>
         !busy && !mass_erase_sel && !erase_sel && !global_mass_erase_sel;
   endproperty
   a_clear_modes: assert property (p_clear_modes) else $error("mode bits kept at end");

   property p_ignore_stray;
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_IDLE && cpu_flash && cpu.we && mass_erase_sel && !addr_ok) |=>
         !busy && !$rose(access_violation_flag_q);
   endproperty
   a_ignore_stray: assert property (p_ignore_stray) else $error("stray dummy write acted");

   property p_stall_fetch;
      @(posedge clk) disable iff (!rstn)
      (cpu_stall && cpu.fetch) |-> cpu_rdata == 16'h3FFF;
   endproperty
   a_stall_fetch: assert property (p_stall_fetch) else $error("stalled fetch not 3FFF");

   property p_flash_stall;
      @(posedge clk) disable iff (!rstn)
      (start_word && cpu.from_flash) |=> cpu_stall throughout (busy [*2]);
   endproperty
   a_flash_stall: assert property (p_flash_stall) else $error("flash write did not stall");

   property p_ram_violation;
      @(posedge clk) disable iff (!rstn)
      (busy && !cpu_stall && cpu_flash && !blk_next) |=> access_violation_flag_q;
   endproperty
   a_ram_violation: assert property (p_ram_violation) else $error("busy access not flagged");

   property p_wren_low;
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_IDLE && cpu_flash && cpu.we && !write_enable_bit && !mass_erase_sel &&
       !erase_sel) |=> access_violation_flag_q && !busy;
   endproperty
   a_wren_low: assert property (p_wren_low) else $error("write with enable low accepted");

   property p_word_tail;
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_WRITE && tick_cnt_q >= WORD_TICKS - 16'd3) |-> !arr.prog_v_on;
   endproperty
   a_word_tail: assert property (p_word_tail) else $error("voltage in word tail");

   property p_lock_toggle;
      @(posedge clk) disable iff (!rstn)
      (apb_wr && paddr == flash_ctl_pkg::STATUS_OFS && !busy) |=>
         info_seg_lock_q == ($past(info_seg_lock_q) ^ $past(pwdata[1]));
   endproperty
   a_lock_toggle: assert property (p_lock_toggle) else $error("lock bit wrong after write");

endmodule

// ===== tb/flash_array_model.sv
// Behavioural flash array driven by the controller's array port.
`timescale 1ns/1ps
module flash_array_model (
   input  wire logic                    clk,
   input  wire flash_ctl_pkg::arr_ctl_t arr,
   output logic [15:0]                  arr_rdata
);
   logic [15:0] mem [0:127];

   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 16'hFFFF;
      end
   end

   always @(posedge clk) begin
      if (arr.erase_v_on) begin
         mem[arr.addr[7:1]] <= 16'hFFFF;
      end else if (arr.prog_v_on) begin
         mem[arr.addr[7:1]] <= mem[arr.addr[7:1]] & ~arr.clr_mask;
      end
   end

   assign arr_rdata = mem[arr.addr[7:1]];
endmodule

// ===== tb/tb_top.sv
// Register and processor-port test of the flash controller.
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] CT = flash_ctl_pkg::CTRL_OFS;
   localparam logic [7:0] ST = flash_ctl_pkg::STATUS_OFS;
   logic                    clk = 0, rstn, psel, penable, pwrite, pready, pslverr, stall, e;
   logic [7:0]              paddr;
   logic [31:0]             pwdata, prdata, r;
   logic [15:0]             cpu_rdata, arr_rdata;
   flash_ctl_pkg::cpu_req_t cpu;
   flash_ctl_pkg::arr_ctl_t arr;
   logic                    tk = 0;
   int                      error_cnt = 0, checks = 0, n, pv = 0;

   always #5 clk = ~clk;
   always @(posedge clk) if (arr.prog_v_on) pv <= pv + 1;
   always @(posedge clk) tk <= ~tk;

   flash_program_erase_controller #(.ERASE_TICKS(16'd20), .WORD_TICKS(16'd8),
      .BLK_WORD_TICKS(16'd6), .BLK_END_TICKS(16'd3)) u_flash_program_erase_controller (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .aux_clk_tick(1'b0), .sub_main_clock_tick(tk), .cpu(cpu), .cpu_rdata(cpu_rdata),
      .cpu_stall(stall), .arr_rdata(arr_rdata), .arr(arr));
   flash_array_model u_flash_array_model (.clk(clk), .arr(arr), .arr_rdata(arr_rdata));

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cop(input logic w, input logic f, input logic [15:0] a, input logic [15:0] d);
      @(posedge clk) cpu <= {1'b1, w, 1'b0, f, a, d};
      @(posedge clk) cpu <= '0;
      #1;
   endtask

   task automatic idle();
      n = 0;
      while (arr.tgen_on !== 1'b0) begin @(posedge clk); #1; n++; end
   endtask

   task automatic test_done();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #100000;
      error_cnt++;
      test_done();
   end

   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, cpu} = '0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apb(0, CT, 0); chk("ctrl", 0, r);
      apb(0, ST, 0); chk("status", 32'h2, r);
      apb(0, 8'h0C, 0); chk("pslverr", 1, e);
      apb(1, flash_ctl_pkg::CLKCFG_OFS, 32'h2);
      apb(1, CT, 32'h2);
      cop(1, 0, 16'h1000, 0); chk("busy", 0, arr.tgen_on);
      cop(1, 0, 16'h4000, 0); chk("busy", 1, arr.tgen_on);
      chk("mode", 2'b10, {arr.erase_main, arr.erase_info});
      idle(); chk("erase", 20, n);
      apb(0, CT, 0); chk("ctrl", 0, r);
      chk("gen", 0, {arr.erase_v_on, arr.prog_v_on});
      apb(1, CT, 32'h40);
      cop(1, 1, 16'h4002, 16'h0123); chk("stall", 1, stall);
      @(posedge clk) cpu <= {1'b1, 1'b0, 1'b1, 1'b1, 16'h4000, 16'h0000};
      #1 chk("opcode", flash_ctl_pkg::JMP_SELF, cpu_rdata);
      @(posedge clk) cpu <= '0;
      idle(); chk("prog", 5, pv);
      chk("stall", 0, stall);
      @(posedge clk) cpu.addr <= 16'h4002;
      #1 chk("data", 16'h0123, cpu_rdata);
      cop(1, 0, 16'h4004, 16'h00FF); chk("stall", 0, stall);
      cop(0, 0, 16'h4000, 0); idle();
      apb(0, ST, 0); chk("status", 32'h6, r);
      apb(1, ST, 32'h4); apb(1, ST, 32'h2);
      apb(0, ST, 0); chk("status", 0, r);
      apb(1, ST, 0); apb(1, CT, 0);
      cop(1, 0, 16'h4010, 0); chk("busy", 0, arr.tgen_on);
      apb(0, ST, 0); chk("status", 32'h4, r);
      apb(1, ST, 32'h4); apb(1, CT, 32'hC0);
      cop(1, 0, 16'h4020, 16'h0F0F); chk("busy", 1, arr.tgen_on);
      do apb(0, ST, 0); while (r[3] !== 1'b1);
      #1 chk("hold", 1, arr.prog_v_on);
      cop(1, 0, 16'h4022, 16'h00F0);
      do apb(0, ST, 0); while (r[3] !== 1'b1);
      apb(1, CT, 0); idle();
      apb(0, ST, 0); chk("status", 0, r);
      @(posedge clk) cpu.addr <= 16'h4020;
      #1 chk("data", 16'h0F0F, cpu_rdata);
      apb(1, flash_ctl_pkg::CLKCFG_OFS, 32'h1); apb(1, CT, 32'h1);
      cop(1, 1, 16'h4000, 0); chk("stall", 1, stall);
      chk("mode", 3'b100, {arr.erase_seg, arr.erase_main, arr.erase_info});
      idle(); chk("ticks", 1, n >= 39 && n <= 40);
      chk("stall", 0, stall);
      test_done();
   end
endmodule
